// ==== rtl/sdc_top.sv ====
/*
 * Digital back end of a dual sigma-delta converter: sinc3 decimation,
 * chop averaging, offset/gain calibration and result FIFO.
 * Assumes modulator bits and the reference-loss flag arrive from the
 * analog side asynchronously; control ports come from logic on CLK_I.
 */
`timescale 1ns/10ps
// Summary of operation
// - Each 1-bit modulator stream is low-pass filtered into multi-bit words.
// - Filter is sinc3; rate word sets cutoff and output word rate.
// - Rate word resets to 45H, just under 20 Hz updates.
// - Rate word valid 13 to 255; lower values are clamped to 13.
// - Both converters chop input polarity on every filter word.
// - New word plus previous word, halved, becomes the new result.
// - First result after a start or channel change takes two periods.
// - Four calibration modes chosen by the converter mode bits.
// - Factory offset and gain coefficients load after reset.
// - Calibration on an enabled converter overwrites its coefficients.
// - Zero-scale result goes to offset, full-scale to gain.
// - Internal calibration selects an internal source, system uses pins.
// - Calibration always runs at the slowest filter rate.
// - Results get offset subtracted, then multiplied by gain.
// - Ready flag sets on calibration end as on conversions.
// - Unipolar gives straight binary, bipolar gives offset binary.
// - Reference loss during calibration blocks update and sets error.
// - Reference loss during conversion forces results to all ones.
module sdc_top
	import sdc_pkg::*;
#(
	parameter int DEC_MULT = 8,
	parameter int MOD_DIV = 4,
	parameter int CIC_W = 34,
	parameter int DEC_W = 12
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	input wire logic [1:0] MOD_BIT_I,
	input wire logic MISSING_REF_I,
	input wire logic [2:0] MODE_I,
	input wire logic START_I,
	input wire logic [1:0] ENABLE_I,
	input wire logic [1:0] CHAN_CHG_I,
	input wire logic [1:0] UNIPOLAR_I,
	input wire logic [7:0] FILTER_RATE_I,
	input wire logic [23:0] FACT_OFS0_I,
	input wire logic [23:0] FACT_GAIN0_I,
	input wire logic [23:0] FACT_OFS1_I,
	input wire logic [23:0] FACT_GAIN1_I,
	input wire logic [1:0] READY_CLR_I,
	input wire logic [1:0] ERR_CLR_I,
	input wire logic RES_READY_I,
	output logic RES_VALID_O,
	output logic [24:0] RES_DATA_O,
	output logic [1:0] CHOP_O,
	output logic [1:0] CAL_SRC0_O,
	output logic [1:0] CAL_SRC1_O,
	output logic [23:0] RESULT0_O,
	output logic [23:0] RESULT1_O,
	output logic [23:0] OFFSET0_O,
	output logic [23:0] GAIN0_O,
	output logic [23:0] OFFSET1_O,
	output logic [23:0] GAIN1_O,
	output logic [1:0] READY_O,
	output logic [1:0] ERR_O,
	output logic [1:0] BUSY_O,
	output logic MISSING_REF_O
);
	// ----------------------------------------------------------------
	// Pin synchronisers and shared timing
	// ----------------------------------------------------------------
	logic [2:0] sync1_q, sync2_q;
	logic [7:0] tick_q;
	logic load_q;
	logic [1:0] pend_q;
	logic [1:0] res_stb;
	logic [7:0] rate_q;
	logic fifo_rdy;
	wire [1:0] mod_s = sync2_q[1:0];
	wire miss_s = sync2_q[2];
	// Stall the tick, filters and control while a result waits for FIFO space
	wire adv = CE_I & ~|pend_q;
	wire tick = adv & (tick_q == 8'(MOD_DIV - 1));
	// Two flops on asynchronous inputs, first stage feeds only the second
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (CE_I) begin
			sync1_q <= {MISSING_REF_I, MOD_BIT_I};
			sync2_q <= sync1_q;
		end
	end
	// Modulator sample tick and factory load request after reset
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			tick_q <= '0;
			load_q <= 1'b1;
		end else begin
			if (tick) begin
				tick_q <= '0;
			end else if (adv) begin
				tick_q <= tick_q + 8'h01;
			end
			if (CE_I) begin
				load_q <= 1'b0;
			end
		end
	end
	// Filter rate word register; holds its default until the port is taken
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rate_q <= RATE_RESET;
		end else if (CE_I) begin
			rate_q <= FILTER_RATE_I;
		end
	end
	// ----------------------------------------------------------------
	// Per-converter datapath
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : ch_g
		sdc_state_t st_q, st_d;
		logic [2:0] mode_q;
		logic chop_q, have_q, refbad_q, rdy_q, err_q, busy_q;
		logic [1:0] chop_dly_q;
		logic [1:0] src_q;
		logic [CIC_W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
		logic [DEC_W-1:0] cnt_q;
		logic [23:0] prev_q, res_q, ofs_q, gain_q, quo_q, span_q;
		logic [25:0] rem_q;
		logic [4:0] dcnt_q;
		// Start, restart and mode decode
		wire go = START_I & ENABLE_I[c];
		wire restart = go | CHAN_CHG_I[c];
		wire [2:0] mode_d = go ? MODE_I : mode_q;
		wire zero = mode_is_zero(mode_q);
		wire in_cal = (st_q == ST_CAL);
		wire in_run = (st_q == ST_RUN);
		wire in_div = (st_q == ST_DIV);
		// Rate word: clamped below the minimum, forced slowest in calibration
		wire [7:0] rate_lim = (rate_q < RATE_MIN) ? RATE_MIN : rate_q;
		wire [7:0] rate = in_cal ? RATE_CAL : rate_lim;
		wire [DEC_W-1:0] len_m1 = DEC_W'(32'(rate) * DEC_MULT - 1);
		// Sinc3 decimator; chop-inverted bit keeps the signal sign fixed
		wire smp = tick & (in_run | in_cal);
		wire bit_x = mod_s[c] ^ chop_dly_q[1];
		wire word_stb = smp & (cnt_q >= len_m1);
		wire [CIC_W-1:0] c1 = i3_q - d1_q;
		wire [CIC_W-1:0] c2 = c1 - d2_q;
		wire [CIC_W-1:0] c3 = c2 - d3_q;
		wire [23:0] fword = c3[CIC_W-1 -: RES_W];
		// Chop average of this and previous word
		wire [24:0] sum = {1'b0, fword} + {1'b0, prev_q};
		wire [23:0] avg = sum[24:1];
		wire avg_stb = word_stb & have_q;
		// Offset then gain correction with output coding
		wire signed [24:0] diff = $signed({1'b0, avg}) - $signed({1'b0, ofs_q});
		wire signed [49:0] prod = 50'(diff * $signed({1'b0, gain_q}));
		wire signed [49:0] scl = prod >>> GAIN_FRAC;
		wire signed [49:0] bip = (scl >>> 1) + $signed({26'h0, RES_MID});
		wire [23:0] coded = UNIPOLAR_I[c] ? sat24(scl) : sat24(bip);
		wire [23:0] res_v = miss_s ? RES_ALL1 : coded;
		// Calibration decisions
		wire refbad = refbad_q | miss_s;
		wire span_ok = diff > $signed({3'h0, GAIN_UNITY});
		wire cal_end = avg_stb & in_cal & ENABLE_I[c];
		wire ofs_wr = cal_end & zero & ~refbad;
		wire full_wr = cal_end & ~zero & ~refbad;
		wire div_go = full_wr & span_ok;
		wire div_end = in_div & (dcnt_q == DIV_LAST);
		wire [25:0] rem_sh = {rem_q[24:0], 1'b0};
		wire rem_ge = rem_sh >= {2'h0, span_q};
		wire [23:0] quo_n = {quo_q[22:0], rem_ge};
		wire cal_done = (cal_end & ~div_go) | div_end;
		assign res_stb[c] = avg_stb & in_run;
		// State selection
		always_comb begin
			st_d = st_q;
			unique case (st_q)
				ST_IDLE: st_d = ST_IDLE;
				ST_RUN: if (avg_stb && mode_q == MODE_SINGLE) begin
					st_d = ST_IDLE;
				end
				ST_CAL: if (avg_stb) begin
					st_d = div_go ? ST_DIV : ST_IDLE;
				end
				ST_DIV: if (div_end) begin
					st_d = ST_IDLE;
				end
			endcase
			if (go) begin
				st_d = mode_is_conv(MODE_I) ? ST_RUN : ST_IDLE;
				if (mode_is_cal(MODE_I)) begin
					st_d = ST_CAL;
				end
			end
			if (!ENABLE_I[c]) begin
				st_d = ST_IDLE;
			end
		end
		// Control state
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				st_q <= ST_IDLE;
				mode_q <= MODE_IDLE;
				src_q <= SRC_PINS;
				busy_q <= 1'b0;
				refbad_q <= 1'b0;
			end else if (adv) begin
				st_q <= st_d;
				mode_q <= mode_d;
				src_q <= (st_d == ST_CAL) ? mode_src(mode_d) : SRC_PINS;
				busy_q <= (st_d != ST_IDLE);
				refbad_q <= ~go & (refbad_q | (in_cal & miss_s));
			end
		end
		// Sinc3 integrators, combs and decimation count
		always_ff @(posedge CLK_I) begin
			if (RESET_I || (adv && restart)) begin
				{i1_q, i2_q, i3_q, d1_q, d2_q, d3_q} <= '0;
				cnt_q <= '0;
			end else if (smp) begin
				i1_q <= i1_q + CIC_W'(bit_x);
				i2_q <= i2_q + i1_q;
				i3_q <= i3_q + i2_q;
				cnt_q <= word_stb ? '0 : cnt_q + DEC_W'(1);
				if (word_stb) begin
					d1_q <= i3_q;
					d2_q <= c1;
					d3_q <= c2;
				end
			end
		end
		// Chop phase delayed by the bit synchroniser depth, else edge samples flip
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				chop_dly_q <= '0;
			end else if (CE_I) begin
				chop_dly_q <= {chop_dly_q[0], chop_q};
			end
		end
		// Chop phase and averaging history, the first word only primes it
		always_ff @(posedge CLK_I) begin
			if (RESET_I || (adv && restart)) begin
				chop_q <= 1'b0;
				have_q <= 1'b0;
				prev_q <= '0;
			end else if (word_stb) begin
				chop_q <= ~chop_q;
				have_q <= 1'b1;
				prev_q <= fword;
			end
		end
		// Result register and flags; a set beats a clear in the same cycle
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				res_q <= '0;
				rdy_q <= 1'b0;
				err_q <= 1'b0;
			end else if (CE_I) begin
				if (adv && res_stb[c]) begin
					res_q <= res_v;
				end
				rdy_q <= (adv & (res_stb[c] | cal_done)) | (rdy_q & ~READY_CLR_I[c]);
				err_q <= (adv & cal_end & refbad) | (err_q & ~ERR_CLR_I[c]);
			end
		end
		// Coefficients: factory load, calibration writes, gain division
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				ofs_q <= '0;
				gain_q <= GAIN_UNITY;
				span_q <= '0;
				rem_q <= '0;
				quo_q <= '0;
				dcnt_q <= '0;
			end else if (CE_I && load_q) begin
				ofs_q <= (c == 0) ? FACT_OFS0_I : FACT_OFS1_I;
				gain_q <= (c == 0) ? FACT_GAIN0_I : FACT_GAIN1_I;
			end else if (adv) begin
				if (ofs_wr) begin
					ofs_q <= avg;
				end
				if (full_wr && !span_ok) begin
					gain_q <= RES_ALL1;
				end
				if (div_go) begin
					span_q <= diff[23:0];
					rem_q <= {3'h0, GAIN_UNITY[22:0]};
					quo_q <= '0;
					dcnt_q <= '0;
				end else if (in_div) begin
					rem_q <= rem_ge ? rem_sh - {2'h0, span_q} : rem_sh;
					quo_q <= quo_n;
					dcnt_q <= dcnt_q + 5'h01;
					if (div_end) begin
						gain_q <= quo_n;
					end
				end
			end
		end
	end
	// ----------------------------------------------------------------
	// Result FIFO, primary converter first when both are waiting
	// ----------------------------------------------------------------
	wire push_ch = ~pend_q[0];
	wire push_ok = CE_I & (|pend_q) & fifo_rdy;
	wire [1:0] pend_clr = push_ok ? (push_ch ? 2'b10 : 2'b01) : 2'b00;
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			pend_q <= '0;
		end else if (CE_I) begin
			pend_q <= ({2{adv}} & res_stb) | (pend_q & ~pend_clr);
		end
	end
	sdc_fifo #(
		.WIDTH(25),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.ce_i(CE_I),
		.in_valid_i(|pend_q),
		.in_ready_o(fifo_rdy),
		.in_data_i({push_ch, push_ch ? ch_g[1].res_q : ch_g[0].res_q}),
		.out_valid_o(RES_VALID_O),
		.out_ready_i(RES_READY_I),
		.out_data_o(RES_DATA_O)
	);
	// ----------------------------------------------------------------
	// Output mapping, all from flops
	// ----------------------------------------------------------------
	assign CHOP_O = {ch_g[1].chop_q, ch_g[0].chop_q};
	assign CAL_SRC0_O = ch_g[0].src_q;
	assign CAL_SRC1_O = ch_g[1].src_q;
	assign RESULT0_O = ch_g[0].res_q;
	assign RESULT1_O = ch_g[1].res_q;
	assign OFFSET0_O = ch_g[0].ofs_q;
	assign GAIN0_O = ch_g[0].gain_q;
	assign OFFSET1_O = ch_g[1].ofs_q;
	assign GAIN1_O = ch_g[1].gain_q;
	assign READY_O = {ch_g[1].rdy_q, ch_g[0].rdy_q};
	assign ERR_O = {ch_g[1].err_q, ch_g[0].err_q};
	assign BUSY_O = {ch_g[1].busy_q, ch_g[0].busy_q};
	assign MISSING_REF_O = miss_s;
	// Clamp a signed value into the unsigned result range
	function automatic logic [23:0] sat24(input logic signed [49:0] v);
		if (v < 0) begin
			return '0;
		end
		if (v > $signed({26'h0, RES_ALL1})) begin
			return RES_ALL1;
		end
		return v[23:0];
	endfunction
endmodule

// ==== rtl/sdc_pkg.sv ====
/*
 * Shared constants for the sigma-delta filter and calibration back end:
 * mode codes, filter rate limits, result coding and coefficient format.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sdc_pkg;
	// ----------------------------------------------------------------
	// Converter modes
	// ----------------------------------------------------------------
	localparam int MODE_W = 3;
	localparam logic [2:0] MODE_PDN = 3'h0;
	localparam logic [2:0] MODE_IDLE = 3'h1;
	localparam logic [2:0] MODE_SINGLE = 3'h2;
	localparam logic [2:0] MODE_CONT = 3'h3;
	localparam logic [2:0] MODE_INT_ZERO = 3'h4;
	localparam logic [2:0] MODE_INT_FULL = 3'h5;
	localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
	localparam logic [2:0] MODE_SYS_FULL = 3'h7;
	// ----------------------------------------------------------------
	// Filter rate word
	// ----------------------------------------------------------------
	localparam int RATE_W = 8;
	localparam logic [7:0] RATE_RESET = 8'h45;
	localparam logic [7:0] RATE_MIN = 8'h0D;
	localparam logic [7:0] RATE_CAL = 8'hFF;
	// ----------------------------------------------------------------
	// Result coding and coefficients
	// ----------------------------------------------------------------
	localparam int RES_W = 24;
	localparam int GAIN_FRAC = 22;
	localparam logic [23:0] GAIN_UNITY = 24'h400000;
	localparam logic [23:0] RES_MID = 24'h800000;
	localparam logic [23:0] RES_ALL1 = 24'hFFFFFF;
	localparam logic [4:0] DIV_LAST = 5'h17;
	localparam logic [1:0] SRC_PINS = 2'h0;
	localparam logic [1:0] SRC_ZERO = 2'h1;
	localparam logic [1:0] SRC_FULL = 2'h2;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RUN = 4'h2,
		ST_CAL = 4'h4,
		ST_DIV = 4'h8
	} sdc_state_t;
	function automatic logic mode_is_cal(input logic [2:0] m);
		return m[2];
	endfunction
	function automatic logic mode_is_conv(input logic [2:0] m);
		return (m == MODE_SINGLE) || (m == MODE_CONT);
	endfunction
	function automatic logic mode_is_zero(input logic [2:0] m);
		return (m == MODE_INT_ZERO) || (m == MODE_SYS_ZERO);
	endfunction
	function automatic logic [1:0] mode_src(input logic [2:0] m);
		if (m == MODE_INT_ZERO) begin
			return SRC_ZERO;
		end
		if (m == MODE_INT_FULL) begin
			return SRC_FULL;
		end
		return SRC_PINS;
	endfunction
endpackage

// ==== rtl/sdc_fifo.sv ====
/*
 * Result FIFO with parameter width and depth, valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset, clock enable.
 */
`timescale 1ns/10ps
module sdc_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q, cnt_d;
	logic full_q, empty_q;
	// ----------------------------------------------------------------
	// Handshake decode
	// ----------------------------------------------------------------
	wire push = ce_i & in_valid_i & ~full_q;
	wire pop = ce_i & out_ready_i & ~empty_q;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready_o = ~full_q;
	assign out_valid_o = ~empty_q;
	assign out_data_o = mem_q[rd_q];
	// Pointers and flags; flags registered so the ports see flop outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else if (ce_i) begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_d;
			full_q <= (cnt_d == (AW+1)'(DEPTH));
			empty_q <= (cnt_d == '0);
		end
	end
	// Storage, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
endmodule

// ==== test/sdc_top_properties.sv ====
/* Port-level checker for sdc_top.
   Assumes a bind from the bench, one clock and synchronous reset. */
`timescale 1ns/10ps
module sdc_top_properties
	import sdc_pkg::*;
#(
	parameter int DEC_MULT = 8,
	parameter int MOD_DIV = 4
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	input wire logic MISSING_REF_I,
	input wire logic [2:0] MODE_I,
	input wire logic START_I,
	input wire logic [1:0] ENABLE_I,
	input wire logic [1:0] READY_CLR_I,
	input wire logic [1:0] ERR_CLR_I,
	input wire logic RES_READY_I,
	input wire logic RES_VALID_O,
	input wire logic [24:0] RES_DATA_O,
	input wire logic [23:0] RESULT0_O,
	input wire logic [23:0] OFFSET1_O,
	input wire logic [23:0] GAIN1_O,
	input wire logic [1:0] READY_O,
	input wire logic [1:0] ERR_O,
	input wire logic [1:0] BUSY_O,
	input wire logic MISSING_REF_O
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Two words at the clamped minimum rate, less a little start skew
	localparam int FIRST_MIN = 2 * 13 * DEC_MULT * MOD_DIV - 4;
	logic [15:0] cnt_q;
	logic first_q;
	logic go0;
	logic ref_old;
	logic ref_q;
	assign go0 = START_I && CE_I && ENABLE_I[0] && (MODE_I == MODE_SINGLE) && !BUSY_O[0];
	// Reference lost on this and the previous edge
	assign ref_old = MISSING_REF_O && ref_q;
	// Saturating age of the primary run; a counter instead of a long repetition
	always_ff @(posedge CLK_I) begin
		if (RESET_I || $rose(BUSY_O[0])) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q != 16'hFFFF) begin
			cnt_q <= cnt_q + 16'h0001;
		end
		first_q <= !RESET_I && ($rose(BUSY_O[0]) || (first_q && !$rose(READY_O[0])));
		ref_q <= MISSING_REF_O;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_busy_start: assert property (go0 |=> BUSY_O[0])
		else $error("busy did not follow start");
	a_first_late: assert property ($rose(READY_O[0]) && first_q |-> cnt_q >= FIRST_MIN)
		else $error("first result came before two words");
	a_ref_ones: assert property (ref_old && $changed(RESULT0_O) |-> RESULT0_O == RES_ALL1)
		else $error("result not all ones without reference");
	a_fifo_hold: assert property (RES_VALID_O && !RES_READY_I |=> RES_VALID_O && $stable(RES_DATA_O))
		else $error("fifo head changed while stalled");
	a_err_sticky: assert property (ERR_O[1] && !ERR_CLR_I[1] |=> ERR_O[1])
		else $error("error flag dropped by itself");
	a_coef_guard: assert property (ref_old && BUSY_O[1] |=> $stable(OFFSET1_O) && $stable(GAIN1_O))
		else $error("coefficient written without reference");
	a_off_coef: assert property (!ENABLE_I[1] && !$past(RESET_I) |=> $stable(OFFSET1_O))
		else $error("disabled converter coefficient changed");
	a_ref_sync: assert property ($rose(MISSING_REF_I) |-> ##[1:4] MISSING_REF_O)
		else $error("reference flag not seen in time");
	a_ready_sticky: assert property (READY_O[0] && !READY_CLR_I[0] |=> READY_O[0])
		else $error("ready flag dropped by itself");
	c_err: cover property ($rose(ERR_O[1]));
	c_stall: cover property (RES_VALID_O && !RES_READY_I [*8]);
	c_first: cover property ($rose(READY_O[0]) && first_q);
endmodule

// ==== test/sdc_mod_model.sv ====
/* Modulator stand-in: density to 1-bit stream per converter.
   Assumes the source codes of sdc_pkg and the bench clock. */
`timescale 1ns/10ps
module sdc_mod_model
	import sdc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] dens0_i,
	input wire logic [7:0] dens1_i,
	input wire logic [1:0] src0_i,
	input wire logic [1:0] src1_i,
	input wire logic [1:0] chop_i,
	output logic [1:0] bit_o
);
	logic [8:0] acc0_q, acc1_q;
	logic [7:0] eff0, eff1;
	// Internal sources override the pins; pins carry what the system applied
	assign eff0 = (src0_i == SRC_ZERO) ? 8'h00 : (src0_i == SRC_FULL) ? 8'hFF : dens0_i;
	assign eff1 = (src1_i == SRC_ZERO) ? 8'h00 : (src1_i == SRC_FULL) ? 8'hFF : dens1_i;
	// Carry is the stream, so its duty cycle tracks the density
	always_ff @(posedge clk_i) begin
		acc0_q <= rst_i ? 9'h000 : {1'b0, acc0_q[7:0]} + {1'b0, eff0};
		acc1_q <= rst_i ? 9'h000 : {1'b0, acc1_q[7:0]} + {1'b0, eff1};
	end
	// Swapped inputs invert the stream while the chop phase is high
	assign bit_o = {acc1_q[8] ^ chop_i[1], acc0_q[8] ^ chop_i[0]};
endmodule

// ==== test/sdc_top_test.sv ====
/* Self-checking bench for sdc_top: calibration, conversion, result FIFO.
   Assumes the modulator model and checker are compiled before it. */
`timescale 1ns/10ps
module sdc_top_test;
	import sdc_pkg::*;
	localparam int DEC_MULT = 8;
	localparam int MOD_DIV = 1;
	logic CLK_I, RESET_I, MISSING_REF_I, START_I, RES_READY_I, RES_VALID_O, MISSING_REF_O;
	logic [1:0] MOD_BIT_I, ENABLE_I, UNIPOLAR_I, ERR_CLR_I, READY_O, ERR_O, BUSY_O, CHOP_O;
	logic [1:0] CAL_SRC0_O, CAL_SRC1_O, ready_clr_m, ready_clr_n, chan;
	logic [2:0] MODE_I;
	logic [7:0] FILTER_RATE_I, dens1;
	logic [23:0] FACT_OFS0_I, FACT_GAIN0_I, FACT_OFS1_I, FACT_GAIN1_I;
	logic [23:0] RESULT0_O, RESULT1_O, OFFSET0_O, GAIN0_O, OFFSET1_O, GAIN1_O;
	logic [23:0] exp_res [2];
	logic [24:0] RES_DATA_O;
	logic [31:0] rng_q;
	logic [24:0] exp_q [$];
	logic hold_rdy, cal_on, ce;
	int fail_count, n_compared;
	// ----------------------------------------------------------------
	// Design, modulator model
	// ----------------------------------------------------------------
	sdc_top #(.DEC_MULT(DEC_MULT), .MOD_DIV(MOD_DIV)) sdc_top_inst (.CLK_I(CLK_I),
		.RESET_I(RESET_I), .CE_I(ce), .MOD_BIT_I(MOD_BIT_I), .MISSING_REF_I(MISSING_REF_I),
		.MODE_I(MODE_I), .START_I(START_I), .ENABLE_I(ENABLE_I), .CHAN_CHG_I(chan),
		.UNIPOLAR_I(UNIPOLAR_I), .FILTER_RATE_I(FILTER_RATE_I), .FACT_OFS0_I(FACT_OFS0_I),
		.FACT_GAIN0_I(FACT_GAIN0_I), .FACT_OFS1_I(FACT_OFS1_I), .FACT_GAIN1_I(FACT_GAIN1_I),
		.READY_CLR_I(ready_clr_m | ready_clr_n), .ERR_CLR_I(ERR_CLR_I),
		.RES_READY_I(RES_READY_I), .RES_VALID_O(RES_VALID_O), .RES_DATA_O(RES_DATA_O),
		.CHOP_O(CHOP_O), .CAL_SRC0_O(CAL_SRC0_O), .CAL_SRC1_O(CAL_SRC1_O),
		.RESULT0_O(RESULT0_O), .RESULT1_O(RESULT1_O), .OFFSET0_O(OFFSET0_O), .GAIN0_O(GAIN0_O),
		.OFFSET1_O(OFFSET1_O), .GAIN1_O(GAIN1_O), .READY_O(READY_O), .ERR_O(ERR_O),
		.BUSY_O(BUSY_O), .MISSING_REF_O(MISSING_REF_O));
	sdc_mod_model sdc_mod_model_inst (.clk_i(CLK_I), .rst_i(RESET_I), .dens0_i(8'h00),
		.dens1_i(dens1), .src0_i(CAL_SRC0_O), .src1_i(CAL_SRC1_O), .chop_i(CHOP_O),
		.bit_o(MOD_BIT_I));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic final_report();
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic start(input logic [2:0] m, input logic [1:0] en);
		@(posedge CLK_I);
		MODE_I <= m;
		ENABLE_I <= en;
		START_I <= 1'b1;
		@(posedge CLK_I);
		START_I <= 1'b0;
	endtask
	// Bounded wait for a converter to go idle
	task automatic wait_idle(input int k);
		int i;
		i = 0;
		@(posedge CLK_I);
		while (BUSY_O[k] !== 1'b0 && i < 8000) begin
			@(posedge CLK_I);
			i++;
		end
		if (i >= 8000) chk(1'b1, 1'b0, "busy timeout");
	endtask
	task automatic clr(input logic [1:0] m);
		@(posedge CLK_I);
		ready_clr_m <= m;
		ERR_CLR_I <= m;
		@(posedge CLK_I);
		ready_clr_m <= 2'h0;
		ERR_CLR_I <= 2'h0;
	endtask
	// ----------------------------------------------------------------
	// Clock, random drive, result noting and FIFO monitor
	// ----------------------------------------------------------------
	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I) begin
		rng_q <= xs(rng_q);
		RES_READY_I <= !hold_rdy && rng_q[3];
		dens1 <= rng_q[15:8];
	end
	// Each new result is noted with its channel, primary first
	always @(posedge CLK_I) begin
		ready_clr_n <= 2'h0;
		for (int k = 0; k < 2; k++) begin
			if (!cal_on && READY_O[k] === 1'b1 && !ready_clr_n[k]) begin
				exp_q.push_back({k[0], exp_res[k]});
				ready_clr_n[k] <= 1'b1;
			end
		end
	end
	always @(posedge CLK_I) begin
		if (!RESET_I && RES_VALID_O === 1'b1 && RES_READY_I === 1'b1) begin
			if (exp_q.size() == 0) chk(1'b1, 1'b0, "unexpected fifo word");
			else chk(RES_DATA_O, exp_q.pop_front(), "fifo word");
		end
	end
	initial begin
		#320000;
		fail_count++;
		final_report();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [2:0] md;
		logic [1:0] src;
		rng_q = 32'h0000007A;
		{fail_count, n_compared, hold_rdy, cal_on} = '0;
		{MISSING_REF_I, START_I, ERR_CLR_I, ready_clr_m, ready_clr_n, chan} = '0;
		ce = 1'b1;
		{RES_READY_I, MODE_I, ENABLE_I, UNIPOLAR_I, dens1} = '0;
		{exp_res[0], exp_res[1]} = '0;
		FILTER_RATE_I = RATE_MIN;
		FACT_OFS0_I = 24'h01A2B3;
		FACT_GAIN0_I = GAIN_UNITY;
		FACT_OFS1_I = 24'h003C4D;
		FACT_GAIN1_I = 24'h3F1E2D;
		RESET_I = 1'b1;
		repeat (12) @(posedge CLK_I);
		RESET_I <= 1'b0;
		repeat (3) @(posedge CLK_I);
		chk(OFFSET0_O, FACT_OFS0_I, "factory offset0");
		chk(GAIN0_O, FACT_GAIN0_I, "factory gain0");
		chk(OFFSET1_O, FACT_OFS1_I, "factory offset1");
		chk(GAIN1_O, FACT_GAIN1_I, "factory gain1");
		// Every calibration mode on the auxiliary side without a reference
		cal_on <= 1'b1;
		MISSING_REF_I <= 1'b1;
		for (int m = 4; m < 8; m++) begin
			md = m[2:0];
			src = (md == MODE_INT_ZERO) ? SRC_ZERO : (md == MODE_INT_FULL) ? SRC_FULL : SRC_PINS;
			start(md, 2'h2);
			repeat (500) @(posedge CLK_I);
			chk(CAL_SRC1_O, src, "cal source");
			chk(BUSY_O[1], 1'b1, "cal at slow rate");
			wait_idle(1);
			chk(ERR_O[1], 1'b1, "cal error");
			chk(READY_O[1], 1'b1, "cal ready");
			chk(OFFSET1_O, FACT_OFS1_I, "offset kept");
			chk(GAIN1_O, FACT_GAIN1_I, "gain kept");
			clr(2'h3);
		end
		// Internal zero on the primary with a good reference
		MISSING_REF_I <= 1'b0;
		start(MODE_INT_ZERO, 2'h1);
		wait_idle(0);
		chk(READY_O[0], 1'b1, "zero cal ready");
		chk(OFFSET0_O, 24'h000000, "zero cal offset");
		chk(OFFSET1_O, FACT_OFS1_I, "other offset kept");
		clr(2'h3);
		cal_on <= 1'b0;
		// Zero input: straight binary, then offset binary with a clamped rate
		UNIPOLAR_I <= 2'h1;
		start(MODE_SINGLE, 2'h1);
		repeat (150) @(posedge CLK_I);
		chk(READY_O[0], 1'b0, "first result early");
		// Clock enable low must hold the conversion where it is
		ce <= 1'b0;
		repeat (70) @(posedge CLK_I);
		chk(BUSY_O[0], 1'b1, "clock enable freeze");
		ce <= 1'b1;
		wait_idle(0);
		chk(RESULT0_O, 24'h000000, "unipolar zero");
		UNIPOLAR_I <= 2'h0;
		FILTER_RATE_I <= 8'h05;
		exp_res[0] <= RES_MID;
		start(MODE_SINGLE, 2'h1);
		// A channel change mid-word restarts the two-word settling
		repeat (100) @(posedge CLK_I);
		chan <= 2'h1;
		@(posedge CLK_I);
		chan <= 2'h0;
		repeat (150) @(posedge CLK_I);
		chk(BUSY_O[0], 1'b1, "restart after channel change");
		wait_idle(0);
		chk(RESULT0_O, RES_MID, "bipolar zero");
		// Fill the FIFO from both converters, then drain at random
		FILTER_RATE_I <= RATE_MIN;
		MISSING_REF_I <= 1'b1;
		hold_rdy <= 1'b1;
		exp_res[0] <= RES_ALL1;
		exp_res[1] <= RES_ALL1;
		repeat (6) @(posedge CLK_I);
		start(MODE_CONT, 2'h3);
		repeat (4200) @(posedge CLK_I);
		chk(exp_q.size() <= 18, 1'b1, "fifo did not stall");
		chk(RES_VALID_O, 1'b1, "fifo full valid");
		ENABLE_I <= 2'h0;
		hold_rdy <= 1'b0;
		repeat (2000) @(posedge CLK_I);
		chk(exp_q.size(), 25'h0, "fifo not drained");
		chk(RES_VALID_O, 1'b0, "fifo empty");
		final_report();
	end
endmodule
bind sdc_top sdc_top_properties #(.DEC_MULT(DEC_MULT), .MOD_DIV(MOD_DIV)) sdc_top_properties_inst (
	.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .MISSING_REF_I(MISSING_REF_I),
	.MODE_I(MODE_I), .START_I(START_I), .ENABLE_I(ENABLE_I), .READY_CLR_I(READY_CLR_I),
	.ERR_CLR_I(ERR_CLR_I), .RES_READY_I(RES_READY_I), .RES_VALID_O(RES_VALID_O),
	.RES_DATA_O(RES_DATA_O), .RESULT0_O(RESULT0_O), .OFFSET1_O(OFFSET1_O), .GAIN1_O(GAIN1_O),
	.READY_O(READY_O), .ERR_O(ERR_O), .BUSY_O(BUSY_O), .MISSING_REF_O(MISSING_REF_O));
